// File: core/npcs_device.sv
// Purpose: clock setup device: config registers, prescaler NCO, feedback NCO,
//          analog enable and phase clock generator
// Assumes: pclk stands for the crystal clock; feedback NCO also counts pclk
// Notes: PLL divider settings take effect only when 0Dh is written
// Summary of operation
// [RL1] crystal clock feeds prescaler NCO, making PLL reference
// [RL2] prescaler gets pattern, reset rate and divisor
// [RL3] feedback NCO gets divisor, pattern, reset rate
// [RL4] host loads 27 MHz table bytes 08h-0Dh
// [RL5] host sends 24.576 MHz 8 kHz bytes only
// [RL6] analog front enable resets low, analog stays off
// [RL7] phase clock generator makes non-overlapping phases
// [RL8] writing 0Dh last makes new PLL settings active
// [RL9] reset rate zero ignores pattern, plain divisor
// [RL10] pattern bits stretch periods, restart at reset rate
`timescale 1ns/10ps
module npcs_nco #(
  parameter int unsigned W = 5
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         run,
  input  wire logic [W-1:0] div,
  input  wire logic [7:0]   seq,
  input  wire logic [2:0]   rate,
  output logic              tick
);
  import npcs_pkg::*;
  logic [W:0] cnt_q;
  logic [2:0] idx_q;
  logic       tick_q;

  // divisor zero would make the reload underflow, so it acts as one
  wire [W:0] eff_div   = (div == '0) ? {{W{1'b0}}, 1'b1} : {1'b0, div};
  wire       seq_ign   = (rate == '0);                       // RL9
  wire       stretch   = ~seq_ign & seq[idx_q];              // RL10
  wire [W:0] reload    = eff_div + {{W{1'b0}}, stretch} - {{W{1'b0}}, 1'b1};
  wire       at_zero   = (cnt_q == '0);
  wire       wrap_idx  = seq_ign | (idx_q == rate);          // RL10
  wire [2:0] idx_d     = wrap_idx ? 3'h0 : idx_q + 3'h1;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_q  <= '0;
      idx_q  <= '0;
      tick_q <= 1'b0;
    end
    else if (!run)
    begin
      cnt_q  <= '0;
      idx_q  <= '0;
      tick_q <= 1'b0;
    end
    else
    begin
      tick_q <= at_zero;
      if (at_zero)
      begin
        cnt_q <= reload;
        idx_q <= idx_d;
      end
      else
        cnt_q <= cnt_q - {{W{1'b0}}, 1'b1};
    end
  end

  assign tick = tick_q;
endmodule // npcs_nco

module npcs_device (
  input  wire logic pclk,
  input  wire logic presetn,
  npcs_if.dev       link,
  output logic      analog_front_enable,
  output logic      bandgap_enable,
  output logic      pll_power,
  output logic      pll_ref_tick,
  output logic      fb_tick,
  output logic      phase1,
  output logic      phase2,
  output logic [1:0] xtal_bias,
  output logic [3:0] charge_pump,
  output logic [2:0] vco_range
);
  import npcs_pkg::*;

  logic [7:0] sys_q;
  logic [7:0] pseq_q;
  logic [7:0] prst_q;
  logic [7:0] kvco_q;
  logic [7:0] ndiv_q;
  logic [7:0] nseq_q;
  logic [7:0] xbias_q;
  logic [7:0] act_pseq_q;
  logic [7:0] act_prst_q;
  logic [7:0] act_ndiv_q;
  logic [7:0] act_nseq_q;
  logic       commit_q;
  logic       rsp_valid_q;
  logic [7:0] rsp_rdata_q;
  logic [1:0] slot_q;
  logic       phase1_q;
  logic       phase2_q;

  function automatic logic [7:0] read_mux(input logic [7:0] a, input logic [7:0] s,
                                          input logic [7:0] ps, input logic [7:0] pr,
                                          input logic [7:0] kv, input logic [7:0] nd,
                                          input logic [7:0] ns, input logic [7:0] xb);
    case (a)
      NPCS_REG_SYS:   read_mux = s;
      NPCS_REG_PSEQ:  read_mux = ps;
      NPCS_REG_PRST:  read_mux = pr;
      NPCS_REG_KVCO:  read_mux = kv;
      NPCS_REG_NDIV:  read_mux = nd;
      NPCS_REG_NSEQ:  read_mux = ns;
      NPCS_REG_XBIAS: read_mux = xb;
      default:        read_mux = 8'h00;
    endcase
  endfunction

  // the device never stalls the link
  assign link.req_ready = 1'b1;

  wire       take     = link.req_valid & link.req_ready;
  wire       wr       = take & link.req_write;
  wire       rd       = take & ~link.req_write;
  wire       wr_sys   = wr & (link.req_addr == NPCS_REG_SYS);
  wire       wr_pseq  = wr & (link.req_addr == NPCS_REG_PSEQ);     // RL2
  wire       wr_prst  = wr & (link.req_addr == NPCS_REG_PRST);     // RL2
  wire       wr_kvco  = wr & (link.req_addr == NPCS_REG_KVCO);
  wire       wr_ndiv  = wr & (link.req_addr == NPCS_REG_NDIV);     // RL3
  wire       wr_nseq  = wr & (link.req_addr == NPCS_REG_NSEQ);     // RL3
  wire       wr_xbias = wr & (link.req_addr == NPCS_REG_XBIAS);    // RL3
  wire [7:0] rd_data  = read_mux(link.req_addr, sys_q, pseq_q, prst_q, kvco_q,
                                 ndiv_q, nseq_q, xbias_q);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sys_q   <= NPCS_RST_SYS;                                     // RL6
      pseq_q  <= NPCS_RST_PSEQ;
      prst_q  <= NPCS_RST_PRST;
      kvco_q  <= NPCS_RST_KVCO;
      ndiv_q  <= NPCS_RST_NDIV;
      nseq_q  <= NPCS_RST_NSEQ;
      xbias_q <= NPCS_RST_XBIAS;
    end
    else
    begin
      if (wr_sys)
        sys_q <= link.req_wdata & NPCS_MASK_SYS;
      if (wr_pseq)
        pseq_q <= link.req_wdata;
      if (wr_prst)
        prst_q <= link.req_wdata;
      // reserved bit 3 must stay zero, so it is not stored
      if (wr_kvco)
        kvco_q <= link.req_wdata & NPCS_MASK_KVCO;
      if (wr_ndiv)
        ndiv_q <= link.req_wdata & NPCS_MASK_NDIV;
      if (wr_nseq)
        nseq_q <= link.req_wdata;
      if (wr_xbias)
        xbias_q <= link.req_wdata;
    end
  end

  // the NCOs run from copies loaded at the 0Dh write, so a half-written set
  // never reaches the dividers; the 0Dh write data itself is xbias_q
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      act_pseq_q <= NPCS_RST_PSEQ;
      act_prst_q <= NPCS_RST_PRST;
      act_ndiv_q <= NPCS_RST_NDIV;
      act_nseq_q <= NPCS_RST_NSEQ;
      commit_q   <= 1'b0;
    end
    else
    begin
      commit_q <= wr_xbias;                                        // RL8
      if (wr_xbias)
      begin
        act_pseq_q <= pseq_q;                                      // RL8
        act_prst_q <= prst_q;
        act_ndiv_q <= ndiv_q;
        act_nseq_q <= nseq_q;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rsp_valid_q <= 1'b0;
      rsp_rdata_q <= 8'h00;
    end
    else
    begin
      rsp_valid_q <= take;
      if (rd)
        rsp_rdata_q <= rd_data;
    end
  end

  assign link.rsp_valid = rsp_valid_q;
  assign link.rsp_rdata = rsp_rdata_q;

  // analog and PLL stay off until software sets the enable; a commit holds the
  // NCOs for one cycle so both restart their patterns together
  wire afe_on  = sys_q[NPCS_AFE_BIT];                              // RL6
  wire nco_run = afe_on & ~commit_q;

  npcs_nco #(.W(NPCS_PDIV_W)) u_prescale (                        // RL1
    .pclk    (pclk),
    .presetn (presetn),
    .run     (nco_run),
    .div     (act_prst_q[NPCS_PDIV_W-1:0]),
    .seq     (act_pseq_q),
    .rate    (act_prst_q[NPCS_PRATE_LSB +: NPCS_RATE_W]),
    .tick    (pll_ref_tick)
  );

  npcs_nco #(.W(NPCS_NDIV_W)) u_feedback (                        // RL3
    .pclk    (pclk),
    .presetn (presetn),
    .run     (nco_run),
    .div     (act_ndiv_q[NPCS_NDIV_W-1:0]),
    .seq     (act_nseq_q),
    .rate    (xbias_q[NPCS_RATE_W-1:0]),
    .tick    (fb_tick)
  );

  // phase clock generator: four slots per input tick group, phase 1 and
  // phase 2 are each one slot wide with an idle slot between, so they can
  // never overlap; input rate follows the sample rate through the feedback NCO
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      slot_q   <= 2'h0;
      phase1_q <= 1'b0;
      phase2_q <= 1'b0;
    end
    else if (!afe_on)
    begin
      slot_q   <= 2'h0;
      phase1_q <= 1'b0;
      phase2_q <= 1'b0;
    end
    else if (fb_tick)
    begin
      slot_q   <= slot_q + 2'h1;                                   // RL7
      phase1_q <= (slot_q == NPCS_PH1_SLOT);                       // RL7
      phase2_q <= (slot_q == NPCS_PH2_SLOT);                       // RL7
    end
  end

  assign phase1              = phase1_q;
  assign phase2              = phase2_q;
  assign analog_front_enable = afe_on;
  assign bandgap_enable      = afe_on;                             // RL6
  assign pll_power           = afe_on;                             // RL6
  assign xtal_bias           = xbias_q[NPCS_XTAL_LSB +: 2];
  assign charge_pump         = kvco_q[NPCS_ICHP_LSB +: 4];
  assign vco_range           = kvco_q[2:0];
endmodule // npcs_device

// File: core/npcs_pkg.sv
// Purpose: shared constants for the NCO prescaler / PLL clock setup pair
// Assumes: byte-wide configuration link, 32-bit APB on the controller side
// Notes: device register offsets, reset values, fields and controller tables
package npcs_pkg;
  // device configuration registers (byte addresses on the link)
  localparam logic [7:0] NPCS_REG_SYS   = 8'h00;
  localparam logic [7:0] NPCS_REG_PSEQ  = 8'h08;
  localparam logic [7:0] NPCS_REG_PRST  = 8'h09;
  localparam logic [7:0] NPCS_REG_KVCO  = 8'h0a;
  localparam logic [7:0] NPCS_REG_NDIV  = 8'h0b;
  localparam logic [7:0] NPCS_REG_NSEQ  = 8'h0c;
  localparam logic [7:0] NPCS_REG_XBIAS = 8'h0d;
  // reset values
  localparam logic [7:0] NPCS_RST_SYS   = 8'h00;
  localparam logic [7:0] NPCS_RST_PSEQ  = 8'h00;
  localparam logic [7:0] NPCS_RST_PRST  = 8'h0a;
  localparam logic [7:0] NPCS_RST_KVCO  = 8'h22;
  localparam logic [7:0] NPCS_RST_NDIV  = 8'h00;
  localparam logic [7:0] NPCS_RST_NSEQ  = 8'h00;
  localparam logic [7:0] NPCS_RST_XBIAS = 8'h48;
  // writable-bit masks
  localparam logic [7:0] NPCS_MASK_SYS  = 8'h80;
  localparam logic [7:0] NPCS_MASK_KVCO = 8'hf7;
  localparam logic [7:0] NPCS_MASK_NDIV = 8'h7f;
  // field layout
  localparam int unsigned NPCS_AFE_BIT   = 7;
  localparam int unsigned NPCS_PDIV_W    = 5;
  localparam int unsigned NPCS_NDIV_W    = 7;
  localparam int unsigned NPCS_SEQ_W     = 8;
  localparam int unsigned NPCS_RATE_W    = 3;
  localparam int unsigned NPCS_PRATE_LSB = 5;
  localparam int unsigned NPCS_XTAL_LSB  = 6;
  localparam int unsigned NPCS_ICHP_LSB  = 4;
  // phase clock generator: four slots per cycle, phase 1 and phase 2 apart
  localparam logic [1:0] NPCS_PH1_SLOT = 2'h0;
  localparam logic [1:0] NPCS_PH2_SLOT = 2'h2;
  // controller APB registers
  localparam logic [7:0] NPCS_APB_CTRL  = 8'h00;
  localparam logic [7:0] NPCS_APB_CMD   = 8'h04;
  localparam logic [7:0] NPCS_APB_STAT  = 8'h08;
  localparam logic [7:0] NPCS_APB_USER0 = 8'h0c;
  localparam logic [7:0] NPCS_APB_USER1 = 8'h10;
  localparam int unsigned NPCS_CTRL_AFE_BIT = 2;
  localparam int unsigned NPCS_CMD_LOAD_BIT = 0;
  localparam int unsigned NPCS_CMD_READ_BIT = 1;
  localparam logic [1:0] NPCS_PROF_27M_8K  = 2'h0;
  localparam logic [1:0] NPCS_PROF_27M_16K = 2'h1;
  localparam logic [1:0] NPCS_PROF_24M_8K  = 2'h2;
  localparam logic [1:0] NPCS_PROF_USER    = 2'h3;
  localparam logic [2:0] NPCS_STEP_LAST = 3'h6;
  // per-profile bytes for 08h..0Dh, index 0 is 08h
  localparam logic [5:0][7:0] NPCS_TBL_27M_8K  = {8'hc2, 8'h04, 8'h15, 8'h31, 8'hef, 8'hda};
  localparam logic [5:0][7:0] NPCS_TBL_27M_16K = {8'hc4, 8'h1a, 8'h19, 8'h17, 8'he9, 8'ha4};
  localparam logic [5:0][7:0] NPCS_TBL_24M_8K  = {8'hc0, 8'h00, 8'h0f, 8'h11, 8'h0a, 8'h00};
  typedef enum logic [1:0] {NPCS_H_IDLE, NPCS_H_ISSUE, NPCS_H_WAIT} npcs_hstate_t;
endpackage

// File: core/npcs_if.sv
// Purpose: byte configuration link between controller and clock setup device
// Assumes: both ends clocked by the same pclk
// Notes: a request is taken on a rising edge with req_valid and req_ready high
`timescale 1ns/10ps
interface npcs_if;
  logic       req_valid;
  logic       req_write;
  logic [7:0] req_addr;
  logic [7:0] req_wdata;
  logic       req_ready;
  logic       rsp_valid;
  logic [7:0] rsp_rdata;

  modport host (
    output req_valid,
    output req_write,
    output req_addr,
    output req_wdata,
    input  req_ready,
    input  rsp_valid,
    input  rsp_rdata
  );
  modport dev (
    input  req_valid,
    input  req_write,
    input  req_addr,
    input  req_wdata,
    output req_ready,
    output rsp_valid,
    output rsp_rdata
  );
endinterface // npcs_if

// File: core/npcs_host.sv
// Purpose: controller that loads the clock setup device over the byte link
// Assumes: software drives it over APB, one-wait-free access phase
// Notes: profile tables cover 27 MHz 8/16 kHz and 24.576 MHz 8 kHz
`timescale 1ns/10ps
module npcs_host (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  npcs_if.host             link
);
  import npcs_pkg::*;

  npcs_hstate_t state_q;
  logic [15:0]  ctrl_q;
  logic [31:0]  user0_q;
  logic [15:0]  user1_q;
  logic         done_q;
  logic [7:0]   rdbk_q;
  logic [31:0]  prdata_q;
  logic         pslverr_q;
  logic [2:0]   step_q;
  logic         reading_q;
  logic         req_valid_q;
  logic         req_write_q;
  logic [7:0]   req_addr_q;
  logic [7:0]   req_wdata_q;

  // step 0 writes the enable byte, steps 1..6 write 08h..0Dh, 0Dh last
  function automatic logic [7:0] step_addr(input logic [2:0] s);
    step_addr = (s == 3'h0) ? NPCS_REG_SYS : NPCS_REG_PSEQ + {5'h00, s} - 8'h01;
  endfunction

  function automatic logic [7:0] step_byte(input logic [2:0] s, input logic [1:0] p,
                                           input logic afe, input logic [31:0] u0,
                                           input logic [15:0] u1);
    logic [2:0]  i;
    logic [47:0] ub;
    i  = s - 3'h1;
    ub = {u1, u0};
    if (s == 3'h0)
      step_byte = {afe, 7'h00};
    else
      case (p)
        NPCS_PROF_27M_8K:  step_byte = NPCS_TBL_27M_8K[i];        // RL4
        NPCS_PROF_27M_16K: step_byte = NPCS_TBL_27M_16K[i];       // RL4
        NPCS_PROF_24M_8K:  step_byte = NPCS_TBL_24M_8K[i];        // RL5
        default:           step_byte = ub[{i, 3'h0} +: 8];
      endcase
  endfunction

  // 08h and 0Ch are don't-care at 24.576 MHz 8 kHz and are not sent
  function automatic logic skip(input logic [2:0] s, input logic [1:0] p);
    skip = (p == NPCS_PROF_24M_8K) &&
           (step_addr(s) == NPCS_REG_PSEQ || step_addr(s) == NPCS_REG_NSEQ);  // RL5
  endfunction

  wire       setup    = psel & ~penable;
  wire       apb_wr   = psel & penable & pwrite & pready;
  wire [1:0] prof     = ctrl_q[1:0];
  wire       afe_val  = ctrl_q[NPCS_CTRL_AFE_BIT];
  wire       idle     = (state_q == NPCS_H_IDLE);
  wire       start_ld = apb_wr & (paddr == NPCS_APB_CMD) & pwdata[NPCS_CMD_LOAD_BIT] & idle;
  wire       start_rd = apb_wr & (paddr == NPCS_APB_CMD) & pwdata[NPCS_CMD_READ_BIT] & idle
                        & ~pwdata[NPCS_CMD_LOAD_BIT];
  wire [2:0] nxt1     = step_q + 3'h1;
  wire [2:0] nxt      = skip(nxt1, prof) ? nxt1 + 3'h1 : nxt1;
  wire       last     = reading_q | (step_q == NPCS_STEP_LAST);    // RL8
  wire       mapped   = (paddr == NPCS_APB_CTRL) | (paddr == NPCS_APB_CMD) |
                        (paddr == NPCS_APB_STAT) | (paddr == NPCS_APB_USER0) |
                        (paddr == NPCS_APB_USER1);
  wire [31:0] rd_mux  = (paddr == NPCS_APB_CTRL)  ? {16'h0000, ctrl_q} :
                        (paddr == NPCS_APB_STAT)  ? {16'h0000, rdbk_q, 6'h00, done_q, ~idle} :
                        (paddr == NPCS_APB_USER0) ? user0_q :
                        (paddr == NPCS_APB_USER1) ? {16'h0000, user1_q} : 32'h0000_0000;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q    <= 16'h0000;
      user0_q   <= 32'h0000_0000;
      user1_q   <= 16'h0000;
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end
    else
    begin
      if (setup)
      begin
        prdata_q  <= rd_mux;
        pslverr_q <= ~mapped;
      end
      if (apb_wr & (paddr == NPCS_APB_CTRL))
        ctrl_q <= pwdata[15:0];
      if (apb_wr & (paddr == NPCS_APB_USER0))
        user0_q <= pwdata;
      if (apb_wr & (paddr == NPCS_APB_USER1))
        user1_q <= pwdata[15:0];
    end
  end

  assign pready  = 1'b1;
  assign prdata  = prdata_q;
  assign pslverr = pslverr_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q     <= NPCS_H_IDLE;
      step_q      <= 3'h0;
      reading_q   <= 1'b0;
      done_q      <= 1'b0;
      rdbk_q      <= 8'h00;
      req_valid_q <= 1'b0;
      req_write_q <= 1'b0;
      req_addr_q  <= 8'h00;
      req_wdata_q <= 8'h00;
    end
    else
      case (state_q)
        NPCS_H_IDLE:
          if (start_ld | start_rd)
          begin
            done_q      <= 1'b0;
            reading_q   <= start_rd;
            step_q      <= 3'h0;
            req_valid_q <= 1'b1;
            req_write_q <= start_ld;
            req_addr_q  <= start_rd ? ctrl_q[15:8] : step_addr(3'h0);
            req_wdata_q <= step_byte(3'h0, prof, afe_val, user0_q, user1_q);
            state_q     <= NPCS_H_ISSUE;
          end
        NPCS_H_ISSUE:
          if (link.req_ready)
          begin
            req_valid_q <= 1'b0;
            state_q     <= NPCS_H_WAIT;
          end
        NPCS_H_WAIT:
          if (link.rsp_valid)
          begin
            if (reading_q)
              rdbk_q <= link.rsp_rdata;
            if (last)
            begin
              done_q  <= 1'b1;
              state_q <= NPCS_H_IDLE;
            end
            else
            begin
              step_q      <= nxt;
              req_valid_q <= 1'b1;
              req_addr_q  <= step_addr(nxt);                       // RL2
              req_wdata_q <= step_byte(nxt, prof, afe_val, user0_q, user1_q);  // RL3
              state_q     <= NPCS_H_ISSUE;
            end
          end
        default:
          state_q <= NPCS_H_IDLE;
      endcase
  end

  assign link.req_valid = req_valid_q;
  assign link.req_write = req_write_q;
  assign link.req_addr  = req_addr_q;
  assign link.req_wdata = req_wdata_q;
endmodule // npcs_host

// File: tb/npcs_sva.sv
// Purpose: link and clock output checks for the setup pair
// Assumes: one pclk domain, presetn active low
// Notes: tick liveness asked only while analog is on
`timescale 1ns/10ps
module npcs_sva
  import npcs_pkg::*;
(
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       req_valid,
  input wire logic       req_write,
  input wire logic [7:0] req_addr,
  input wire logic [7:0] req_wdata,
  input wire logic       req_ready,
  input wire logic       rsp_valid,
  input wire logic       analog_front_enable,
  input wire logic       bandgap_enable,
  input wire logic       pll_power,
  input wire logic       pll_ref_tick,
  input wire logic       fb_tick,
  input wire logic       phase1,
  input wire logic       phase2
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_rsp_follows: assert property (req_valid && req_ready |=> rsp_valid)
    else $error("no link response");
  a_rsp_cause: assert property (rsp_valid |-> $past(req_valid && req_ready))
    else $error("stray link response");
  a_afe_reset: assert property ($rose(presetn) |-> !analog_front_enable)
    else $error("analog on after reset");
  a_afe_write: assert property (req_valid && req_ready && req_write && req_addr == NPCS_REG_SYS
    |=> analog_front_enable == $past(req_wdata[NPCS_AFE_BIT]))
    else $error("analog enable not written");
  a_bias_follow: assert property ({bandgap_enable, pll_power} == {2{analog_front_enable}})
    else $error("bias differs from enable");
  a_phase_apart: assert property (!(phase1 && phase2))
    else $error("phases overlap");
  a_ph1_tick: assert property ($rose(phase1) |-> $past(fb_tick))
    else $error("phase1 rose without tick");
  a_ph2_tick: assert property ($rose(phase2) |-> $past(fb_tick))
    else $error("phase2 rose without tick");
  a_ref_alive: assert property (pll_ref_tick |-> ##[1:300] (pll_ref_tick || !analog_front_enable))
    else $error("reference tick stopped");
  a_fb_alive: assert property (fb_tick |-> ##[1:300] (fb_tick || !analog_front_enable))
    else $error("feedback tick stopped");

  c_write: cover property (req_valid && req_write);
  c_read: cover property (req_valid && !req_write);
  c_ph2: cover property ($rose(phase2));
endmodule // npcs_sva

// File: tb/tb_top.sv
// Purpose: self-checking bench for controller and device pair
// Assumes: 100 MHz pclk, zero-wait APB
// Notes: spans cover whole pattern cycles, so start index is irrelevant
`timescale 1ns/10ps
module tb_top;
  import npcs_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, e;
  logic [7:0]  paddr, last_addr;
  logic [31:0] pwdata, prdata, r;
  logic        afe, bg, pwr, rt, ft, ph1, ph2;
  logic [1:0]  xb;
  logic [3:0]  cp;
  logic [2:0]  vr;
  int          mismatches, n_tests, n_req;
  int          p_exp [4] = '{125, 75, 80, 252};
  int          f_n [4] = '{3, 5, 8, 8};
  int          f_exp [4] = '{64, 128, 120, 1017};
  int          n_exp [4] = '{7, 7, 5, 7};
  logic [8:0]  o_exp [4] = '{9'h199, 9'h18f, 9'h189, 9'h0ff};

  npcs_if link ();
  npcs_host npcs_host_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(e), .link(link));
  npcs_device npcs_device_inst (.pclk(pclk), .presetn(presetn), .link(link),
    .analog_front_enable(afe), .bandgap_enable(bg), .pll_power(pwr), .pll_ref_tick(rt),
    .fb_tick(ft), .phase1(ph1), .phase2(ph2), .xtal_bias(xb), .charge_pump(cp),
    .vco_range(vr));
  npcs_sva npcs_sva_inst (.pclk(pclk), .presetn(presetn), .req_valid(link.req_valid),
    .req_write(link.req_write), .req_addr(link.req_addr), .req_wdata(link.req_wdata),
    .req_ready(link.req_ready), .rsp_valid(link.rsp_valid), .analog_front_enable(afe),
    .bandgap_enable(bg), .pll_power(pwr), .pll_ref_tick(rt), .fb_tick(ft),
    .phase1(ph1), .phase2(ph2));

  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // link monitor: counts taken requests, remembers the last address
  always @(posedge pclk)
  begin
    if (link.req_valid === 1'b1 && link.req_ready === 1'b1)
    begin
      n_req <= n_req + 1;
      last_addr <= link.req_addr;
    end
  end

  task stop_test();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task hang(input string what);
    $display("[FAIL] %s expected done seen timeout", what);
    mismatches++;
    stop_test();
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do
    begin
      @(posedge pclk);
      i++;
    end
    while (pready !== 1'b1 && i < 20);
    if (i >= 20)
      hang("pready");
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // busy must clear and done must be set; the stale done is hidden by busy
  task wait_done();
    int i;
    i = 0;
    r = 32'h0;
    while (r[1:0] !== 2'b10)
    begin
      apb(1'b0, NPCS_APB_STAT, 32'h0);
      i++;
      if (i > 50)
        hang("load");
    end
  endtask

  task load(input logic [1:0] p, input logic en);
    apb(1'b1, NPCS_APB_CTRL, {29'h0, en, p});
    apb(1'b1, NPCS_APB_CMD, 32'h1);
    wait_done();
  endtask

  // cycles from one tick to the n-th tick after it; for phase1, from rise to rise
  task span(input logic [1:0] sel, input int n, output int c);
    int k;
    int t;
    logic s;
    logic pv;
    c = 0;
    k = 0;
    t = 0;
    pv = 1'b1;
    while (k <= n)
    begin
      @(negedge pclk);
      t++;
      if (k > 0)
        c++;
      s = (sel == 2'h0) ? rt : (sel == 2'h1) ? ft : ph1;
      // phase1 is a level: only a rise counts, and pv starts high so a stale level is skipped
      if (s === 1'b1 && (sel != 2'h2 || pv === 1'b0))
        k++;
      pv = s;
      if (t > 6000)
        hang("tick");
    end
  endtask

  initial
  begin
    int c;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("analog", 32'h0, {afe, bg, pwr});
    chk("reset outs", 32'h092, {xb, cp, vr});
    apb(1'b1, NPCS_APB_USER0, 32'h7fff3f02);
    apb(1'b1, NPCS_APB_USER1, 32'h00004780);
    for (int i = 0; i < 4; i++)
    begin
      c = n_req;
      load(2'(i), 1'b1);
      chk("link writes", n_exp[i], n_req - c);
      chk("last addr", NPCS_REG_XBIAS, last_addr);
      chk("analog", 32'h7, {afe, bg, pwr});
      chk("pll outs", o_exp[i], {xb, cp, vr});
      span(2'h0, 8, c);
      chk("ref span", p_exp[i], c);
      span(2'h1, f_n[i], c);
      chk("fb span", f_exp[i], c);
      span(2'h2, f_n[i], c);
      chk("phase span", 4 * f_exp[i], c);
    end
    apb(1'b1, NPCS_APB_CTRL, 32'h0a07);
    apb(1'b1, NPCS_APB_CMD, 32'h2);
    wait_done();
    chk("readback", 32'hf7, r[15:8]);
    apb(1'b0, 8'h20, 32'h0);
    chk("slverr", 32'h1, e);
    chk("unmapped", 32'h0, r);
    load(NPCS_PROF_27M_8K, 1'b0);
    chk("analog", 32'h0, {afe, bg, pwr});
    stop_test();
  end
endmodule // tb_top
